// ### rtl/pss_defs.vh
// offsets, field positions and reset values of the status summary bank
`ifndef PSS_DEFS_VH
`define PSS_DEFS_VH

// register offsets (5-bit management address)
`define PSS_ADDR_W            5
`define PSS_ADDR_ANEG_EXP     5'h06
`define PSS_ADDR_SUMMARY      5'h10
`define PSS_ADDR_INT_EVENT    5'h12
`define PSS_ADDR_FALSE_CAR    5'h14
`define PSS_ADDR_RX_ERR       5'h15
`define PSS_ADDR_TENBASE      5'h1A
`define PSS_ADDR_IRQ_STATUS   5'h1C
`define PSS_ADDR_IRQ_CLEAR    5'h1D
`define PSS_ADDR_IRQ_ENABLE   5'h1E

// data width
`define PSS_DATA_W            16

// summary register fields
`define PSS_SUM_RESERVED      15
`define PSS_SUM_CROSSOVER     14
`define PSS_SUM_RX_ERR        13
`define PSS_SUM_POLARITY      12
`define PSS_SUM_FALSE_CAR     11
`define PSS_SUM_SIG_DETECT    10
`define PSS_SUM_LOCK          9
`define PSS_SUM_PAGE_RX       8
`define PSS_SUM_INT_PEND      7

// interrupt event register fields: enables low byte, latched events high byte
`define PSS_EVT_W             8
`define PSS_EVT_EN_LSB        0
`define PSS_EVT_LAT_LSB       8

// block interrupt status bits
`define PSS_IRQ_W             6
`define PSS_IRQ_RX_ERR        0
`define PSS_IRQ_FALSE_CAR     1
`define PSS_IRQ_SD_LOST       2
`define PSS_IRQ_LOCK_LOST     3
`define PSS_IRQ_PAGE_RX       4
`define PSS_IRQ_INT_PEND      5

// reset values
`define PSS_RST_DATA          16'h0000
`define PSS_RST_EVT           8'h00
`define PSS_RST_IRQ           6'h00

`endif

// ### rtl/pss_flag.v
// one latching status flag, latching high or latching low
module pss_flag #(
    parameter LATCH_LOW = 0
) (
    // clock and control
    input  wire clk,
    input  wire rst_n,
    input  wire ce,
    // source and clear
    input  wire src,
    input  wire clr,
    // flag
    output reg  flag
);

    always @(posedge clk) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else if (ce) begin
            if (LATCH_LOW != 0) begin
                // a loss beats the read, so a drop in the read cycle is kept
                if (!src) begin
                    flag <= 1'b0;
                end else if (clr) begin
                    flag <= 1'b1;
                end
            end else begin
                // set wins over the clear, no event is lost
                if (src) begin
                    flag <= 1'b1;
                end else if (clr) begin
                    flag <= 1'b0;
                end
            end
        end
    end

endmodule // pss_flag

// ### rtl/pss_status_summary.v
// status summary register bank, upper bits, with interrupt event logic
`include "pss_defs.vh"

module pss_status_summary (
    // clock, reset, enable
    input  wire                      clk,
    input  wire                      rst_n,
    input  wire                      ce,
    // register port
    input  wire [`PSS_ADDR_W-1:0]    regAddr,
    input  wire [`PSS_DATA_W-1:0]    regWdata,
    input  wire                      regWr,
    input  wire                      regRd,
    output reg  [`PSS_DATA_W-1:0]    regRdata,
    // crossover control and algorithm state
    input  wire                      crossoverAutoEnable,
    input  wire                      crossoverForce,
    input  wire                      crossoverSwapped,
    // receive path events
    input  wire                      rxErrorEvent,
    input  wire                      falseCarrierEvent,
    input  wire                      polarityInverted,
    input  wire                      pageReceivedEvent,
    // medium signals, asynchronous, and the qualify enable, used directly
    input  wire                      rawSignalDetect,
    input  wire                      descramblerLock,
    input  wire                      sdQualifyEnable,
    // interrupt sources
    input  wire [`PSS_EVT_W-1:0]     intEvents,
    // outputs
    output reg                       signalDetectQualified,
    output reg                       intPending,
    output reg                       irq
);

    // address decode
    function rdHit;
        input [`PSS_ADDR_W-1:0] a;
        input [`PSS_ADDR_W-1:0] target;
        input                   strobe;
        begin
            rdHit = strobe & (a == target);
        end
    endfunction

    wire rdSummary = rdHit(regAddr, `PSS_ADDR_SUMMARY, regRd);
    wire rdRxErr   = rdHit(regAddr, `PSS_ADDR_RX_ERR, regRd);
    wire rdFalse   = rdHit(regAddr, `PSS_ADDR_FALSE_CAR, regRd);
    wire rdTenbase = rdHit(regAddr, `PSS_ADDR_TENBASE, regRd);
    wire rdAneg    = rdHit(regAddr, `PSS_ADDR_ANEG_EXP, regRd);
    wire rdIntEvt  = rdHit(regAddr, `PSS_ADDR_INT_EVENT, regRd);
    wire wrIntEvt  = rdHit(regAddr, `PSS_ADDR_INT_EVENT, regWr);
    wire wrIrqClr  = rdHit(regAddr, `PSS_ADDR_IRQ_CLEAR, regWr);
    wire wrIrqEn   = rdHit(regAddr, `PSS_ADDR_IRQ_ENABLE, regWr);

    // two-stage synchronisers for medium signals
    // only the second stage is read; the first may still be settling
    reg sdMeta_r;
    reg sdSync_r;
    reg lockMeta_r;
    reg lockSync_r;

    always @(posedge clk) begin
        if (!rst_n) begin
            sdMeta_r   <= 1'b0;
            sdSync_r   <= 1'b0;
            lockMeta_r <= 1'b0;
            lockSync_r <= 1'b0;
        end else if (ce) begin
            sdMeta_r   <= rawSignalDetect;
            sdSync_r   <= sdMeta_r;
            lockMeta_r <= descramblerLock;
            lockSync_r <= lockMeta_r;
        end
    end

    // qualified signal detect: raw alone, or raw and lock
    wire sdQualNxt = sdQualifyEnable ? (sdSync_r & lockSync_r) : sdSync_r;

    // crossover state; force wins over the algorithm
    reg crossover_r;
    wire crossoverNxt = crossoverForce ? 1'b1 :
                        (crossoverAutoEnable ? crossoverSwapped : 1'b0);

    always @(posedge clk) begin
        if (!rst_n) begin
            crossover_r           <= 1'b0;
            signalDetectQualified <= 1'b0;
        end else if (ce) begin
            crossover_r           <= crossoverNxt;
            signalDetectQualified <= sdQualNxt;
        end
    end

    // latched summary flags
    wire rxErrFlag;
    wire polarityFlag;
    wire falseCarFlag;
    wire sdFlag;
    wire lockFlag;
    wire pageFlag;

    pss_flag #(.LATCH_LOW(0)) uRxErr (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .src   (rxErrorEvent),
        .clr   (rdRxErr),
        .flag  (rxErrFlag)
    );

    // summary reads leave the polarity flag alone
    pss_flag #(.LATCH_LOW(0)) uPolarity (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .src   (polarityInverted),
        .clr   (rdTenbase),
        .flag  (polarityFlag)
    );

    pss_flag #(.LATCH_LOW(0)) uFalseCar (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .src   (falseCarrierEvent),
        .clr   (rdFalse),
        .flag  (falseCarFlag)
    );

    pss_flag #(.LATCH_LOW(1)) uSigDetect (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .src   (sdQualNxt),
        .clr   (rdSummary),
        .flag  (sdFlag)
    );

    pss_flag #(.LATCH_LOW(1)) uLock (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .src   (lockSync_r),
        .clr   (rdSummary),
        .flag  (lockFlag)
    );

    pss_flag #(.LATCH_LOW(0)) uPageRx (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .src   (pageReceivedEvent),
        .clr   (rdAneg),
        .flag  (pageFlag)
    );

    // interrupt event register: enables written, events latched
    reg  [`PSS_EVT_W-1:0] evtEnable_r;
    reg  [`PSS_EVT_W-1:0] evtLatched_r;
    wire [`PSS_EVT_W-1:0] evtEnabledHits = intEvents & evtEnable_r;
    wire                  pendSet        = |evtEnabledHits;

    always @(posedge clk) begin
        if (!rst_n) begin
            evtEnable_r  <= `PSS_RST_EVT;
            evtLatched_r <= `PSS_RST_EVT;
        end else if (ce) begin
            if (wrIntEvt) begin
                evtEnable_r <= regWdata[`PSS_EVT_EN_LSB +: `PSS_EVT_W];
            end
            // fresh events survive the clearing read
            evtLatched_r <= evtEnabledHits | (rdIntEvt ? `PSS_RST_EVT : evtLatched_r);
        end
    end

    // pending flag, cleared by the event register read, set wins
    always @(posedge clk) begin
        if (!rst_n) begin
            intPending <= 1'b0;
        end else if (ce) begin
            if (pendSet) begin
                intPending <= 1'b1;
            end else if (rdIntEvt) begin
                intPending <= 1'b0;
            end
        end
    end

    // edge detect for the block interrupt: falls of qualified detect and lock, rise of pending
    reg sdPrev_r;
    reg lockPrev_r;
    reg pendPrev_r;

    always @(posedge clk) begin
        if (!rst_n) begin
            sdPrev_r   <= 1'b0;
            lockPrev_r <= 1'b0;
            pendPrev_r <= 1'b0;
        end else if (ce) begin
            sdPrev_r   <= sdQualNxt;
            lockPrev_r <= lockSync_r;
            pendPrev_r <= intPending;
        end
    end

    wire [`PSS_IRQ_W-1:0] irqEvents;
    assign irqEvents[`PSS_IRQ_RX_ERR]    = rxErrorEvent;
    assign irqEvents[`PSS_IRQ_FALSE_CAR] = falseCarrierEvent;
    assign irqEvents[`PSS_IRQ_SD_LOST]   = sdPrev_r & ~sdQualNxt;
    assign irqEvents[`PSS_IRQ_LOCK_LOST] = lockPrev_r & ~lockSync_r;
    assign irqEvents[`PSS_IRQ_PAGE_RX]   = pageReceivedEvent;
    assign irqEvents[`PSS_IRQ_INT_PEND]  = intPending & ~pendPrev_r;

    // block interrupt: sticky status, write-one-to-clear, enable
    // status and enable share one layout so software masks bit by bit
    reg  [`PSS_IRQ_W-1:0] irqStatus_r;
    reg  [`PSS_IRQ_W-1:0] irqEnable_r;
    wire [`PSS_IRQ_W-1:0] irqClrMask = wrIrqClr ? regWdata[`PSS_IRQ_W-1:0] : `PSS_RST_IRQ;
    wire [`PSS_IRQ_W-1:0] irqStatusNxt = irqEvents | (irqStatus_r & ~irqClrMask);
    wire [`PSS_IRQ_W-1:0] irqEnableNxt = wrIrqEn ? regWdata[`PSS_IRQ_W-1:0] : irqEnable_r;

    always @(posedge clk) begin
        if (!rst_n) begin
            irqStatus_r <= `PSS_RST_IRQ;
            irqEnable_r <= `PSS_RST_IRQ;
            irq         <= 1'b0;
        end else if (ce) begin
            irqStatus_r <= irqStatusNxt;
            irqEnable_r <= irqEnableNxt;
            // level output follows next state so it tracks the status bits
            irq         <= |(irqStatusNxt & irqEnableNxt);
        end
    end

    // summary word; bits 6..0 belong to another unit and read zero here
    reg [`PSS_DATA_W-1:0] summaryWord;

    always @* begin
        summaryWord                      = `PSS_RST_DATA;
        summaryWord[`PSS_SUM_RESERVED]   = 1'b0;
        summaryWord[`PSS_SUM_CROSSOVER]  = crossover_r;
        summaryWord[`PSS_SUM_RX_ERR]     = rxErrFlag;
        summaryWord[`PSS_SUM_POLARITY]   = polarityFlag;
        summaryWord[`PSS_SUM_FALSE_CAR]  = falseCarFlag;
        summaryWord[`PSS_SUM_SIG_DETECT] = sdFlag;
        summaryWord[`PSS_SUM_LOCK]       = lockFlag;
        summaryWord[`PSS_SUM_PAGE_RX]    = pageFlag;
        summaryWord[`PSS_SUM_INT_PEND]   = intPending;
    end

    // read mux; the summary has no write path at all
    reg [`PSS_DATA_W-1:0] rdMux;

    always @* begin
        rdMux = `PSS_RST_DATA;
        case (regAddr)
            `PSS_ADDR_SUMMARY: begin
                rdMux = summaryWord;
            end
            `PSS_ADDR_INT_EVENT: begin
                rdMux[`PSS_EVT_EN_LSB +: `PSS_EVT_W]  = evtEnable_r;
                rdMux[`PSS_EVT_LAT_LSB +: `PSS_EVT_W] = evtLatched_r;
            end
            `PSS_ADDR_IRQ_STATUS: begin
                rdMux[`PSS_IRQ_W-1:0] = irqStatus_r;
            end
            `PSS_ADDR_IRQ_ENABLE: begin
                rdMux[`PSS_IRQ_W-1:0] = irqEnable_r;
            end
            default: begin
                rdMux = `PSS_RST_DATA;
            end
        endcase
    end

    // read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        if (!rst_n) begin
            regRdata <= `PSS_RST_DATA;
        end else if (ce) begin
            regRdata <= regRd ? rdMux : `PSS_RST_DATA;
        end
    end

endmodule // pss_status_summary

// ### verification/pss_status_summary_assertions.sv
// concurrent checks on the status summary bank ports
module pss_status_summary_assertions (
    // clock and control
    input wire        clk,
    input wire        rst_n,
    input wire        ce,
    // register port
    input wire [4:0]  regAddr,
    input wire        regRd,
    input wire [15:0] regRdata,
    // sources
    input wire        crossoverAutoEnable,
    input wire        crossoverForce,
    input wire        crossoverSwapped,
    input wire        rxErrorEvent,
    input wire        falseCarrierEvent,
    input wire        rawSignalDetect,
    input wire        descramblerLock,
    input wire        sdQualifyEnable,
    input wire [7:0]  intEvents,
    // outputs
    input wire        signalDetectQualified,
    input wire        intPending
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence sumRd;
        ce && $past(ce) && regRd && regAddr == 5'h10;
    endsequence
    sequence rxSeen;
        ce && rxErrorEvent ##1 !(regRd && regAddr == 5'h15) ##1 sumRd;
    endsequence
    sequence fcSeen;
        ce && falseCarrierEvent ##1 !(regRd && regAddr == 5'h14) ##1 sumRd;
    endsequence
    idle_data_zero_a: assert property ($past(ce) && !$past(regRd) |-> regRdata == 16'h0000)
        else $error("read data not zero outside a read");
    reserved_bits_a: assert property (sumRd |=> !regRdata[15] && regRdata[6:0] == 7'h00)
        else $error("reserved summary bits not zero");
    crossover_bit_a: assert property (sumRd |=> regRdata[14] == ($past(crossoverForce, 2)
        | ($past(crossoverAutoEnable, 2) & $past(crossoverSwapped, 2))))
        else $error("crossover bit wrong");
    rx_err_latch_a: assert property (rxSeen |=> regRdata[13])
        else $error("receive error not latched");
    false_car_latch_a: assert property (fcSeen |=> regRdata[11])
        else $error("false carrier not latched");
    pending_bit_a: assert property (sumRd |=> regRdata[7] == $past(intPending))
        else $error("pending bit differs from pending output");
    pending_clear_a: assert property (ce && regRd && regAddr == 5'h12 && intEvents == 8'h00
        |=> !intPending)
        else $error("pending not cleared by event read");
    pending_cause_a: assert property ($rose(intPending) |-> $past(intEvents) != 8'h00)
        else $error("pending rose without an event");
    sd_lock_gate_a: assert property ((ce && sdQualifyEnable && !descramblerLock)[*4]
        |=> !signalDetectQualified)
        else $error("qualified detect high without lock");
    sd_raw_low_a: assert property ((ce && !rawSignalDetect)[*4] |=> !signalDetectQualified)
        else $error("qualified detect high without raw detect");
endmodule // pss_status_summary_assertions

bind pss_status_summary pss_status_summary_assertions u_pss_status_summary_assertions (
    .clk(clk), .rst_n(rst_n), .ce(ce), .regAddr(regAddr), .regRd(regRd), .regRdata(regRdata),
    .crossoverAutoEnable(crossoverAutoEnable), .crossoverForce(crossoverForce),
    .crossoverSwapped(crossoverSwapped), .rxErrorEvent(rxErrorEvent),
    .falseCarrierEvent(falseCarrierEvent), .rawSignalDetect(rawSignalDetect),
    .descramblerLock(descramblerLock), .sdQualifyEnable(sdQualifyEnable),
    .intEvents(intEvents), .signalDetectQualified(signalDetectQualified),
    .intPending(intPending));

// ### verification/pss_status_summary_tb_top.sv
// self-checking bench for the status summary bank
module pss_status_summary_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst_n = 0, ce = 1, regWr = 0, regRd = 0;
    logic [4:0]  regAddr = 5'h00;
    logic [15:0] regWdata = 16'h0000, d;
    logic        xf = 0, xa = 0, xs = 0, raw = 0, lock = 0, sdq = 0;
    logic [11:0] ev = 12'h000;
    wire  [15:0] regRdata;
    wire         sdOut, intPending, irq;
    int          failCount = 0, checksDone = 0;
    // crossover rows: force, auto, swapped, expected bit
    logic [3:0]  xRow [8] = '{4'h0, 4'h2, 4'h4, 4'h7, 4'h9, 4'hB, 4'hD, 4'hF};
    // latch flags: clearing address and summary bit, in event order
    logic [4:0]  clrA [4] = '{5'h15, 5'h14, 5'h1A, 5'h06};
    int          bn [4] = '{13, 11, 12, 8};

    pss_status_summary u_pss_status_summary (
        .clk(clk), .rst_n(rst_n), .ce(ce), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .crossoverAutoEnable(xa),
        .crossoverForce(xf), .crossoverSwapped(xs), .rxErrorEvent(ev[0]),
        .falseCarrierEvent(ev[1]), .polarityInverted(ev[2]), .pageReceivedEvent(ev[3]),
        .rawSignalDetect(raw), .descramblerLock(lock), .sdQualifyEnable(sdq),
        .intEvents(ev[11:4]), .signalDetectQualified(sdOut), .intPending(intPending),
        .irq(irq));

    always #5 clk = ~clk;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checksDone++;
        if (seen !== exp) begin
            failCount++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // every task starts and ends just after a rising edge
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask
    // data stand only in the cycle after the strobe, so capture just past the edge
    task automatic rd(input logic [4:0] a);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdata;
        @(posedge clk);
    endtask
    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
        @(posedge clk);
    endtask
    task automatic printVerdict();
        $display("checks %0d mismatches %0d", checksDone, failCount);
        if (failCount == 0 && checksDone > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failCount++;
        printVerdict();
    end

    initial begin
        repeat (12) @(posedge clk);
        chk({regRdata[15:3], sdOut, intPending, irq}, 16'h0000);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(5'h10);
        chk(d, 16'h0000);
        wr(5'h10, 16'hFFFF);
        rd(5'h10);
        chk(d, 16'h0000);
        foreach (xRow[r]) begin
            {xf, xa, xs} <= xRow[r][3:1];
            @(posedge clk);
            rd(5'h10);
            chk(d, {1'b0, xRow[r][0], 14'h0000});
        end
        {xf, xa, xs} <= 3'h0;
        foreach (clrA[i]) begin
            pulse(i);
            rd(5'h10);
            chk(d, 16'h0001 << bn[i]);
            rd(5'h10);
            chk(d, 16'h0001 << bn[i]);
            rd(clrA[i]);
            rd(5'h10);
            chk(d, 16'h0000);
        end
        // latched-low bits re-arm only by a read
        raw <= 1'b1;
        lock <= 1'b1;
        sdq <= 1'b1;
        repeat (6) @(posedge clk);
        chk({15'h0000, sdOut}, 16'h0001);
        rd(5'h10);
        rd(5'h10);
        chk({14'h0000, d[10:9]}, 16'h0003);
        lock <= 1'b0;
        repeat (4) @(posedge clk);
        chk({15'h0000, sdOut}, 16'h0000);
        lock <= 1'b1;
        repeat (6) @(posedge clk);
        rd(5'h10);
        chk({14'h0000, d[10:9]}, 16'h0000);
        rd(5'h10);
        chk({14'h0000, d[10:9]}, 16'h0003);
        sdq <= 1'b0;
        lock <= 1'b0;
        repeat (6) @(posedge clk);
        rd(5'h10);
        chk({14'h0000, d[10:9]}, 16'h0002);
        chk({15'h0000, sdOut}, 16'h0001);
        wr(5'h12, 16'h0001);
        pulse(5);
        chk({15'h0000, intPending}, 16'h0000);
        pulse(4);
        chk({15'h0000, intPending}, 16'h0001);
        rd(5'h10);
        chk(d & 16'h0080, 16'h0080);
        rd(5'h12);
        chk(d & 16'h01FF, 16'h0101);
        chk({15'h0000, intPending}, 16'h0000);
        wr(5'h1D, 16'h003F);
        wr(5'h1E, 16'h0001);
        pulse(0);
        chk({15'h0000, irq}, 16'h0001);
        wr(5'h1D, 16'h0001);
        chk({15'h0000, irq}, 16'h0000);
        wr(5'h1E, 16'h0000);
        pulse(0);
        chk({15'h0000, irq}, 16'h0000);
        rd(5'h1C);
        chk(d & 16'h0001, 16'h0001);
        rd(5'h1D);
        chk(d, 16'h0000);
        rd(5'h03);
        chk(d, 16'h0000);
        // a clearing read in the event cycle must not lose the event
        rd(5'h15);
        ev[0] <= 1'b1;
        regAddr <= 5'h15;
        regRd <= 1'b1;
        @(posedge clk);
        ev[0] <= 1'b0;
        regRd <= 1'b0;
        @(posedge clk);
        rd(5'h10);
        chk(d & 16'h2000, 16'h2000);
        // with the enable low an event leaves no trace
        rd(5'h15);
        ce <= 1'b0;
        pulse(0);
        ce <= 1'b1;
        rd(5'h10);
        chk(d & 16'h2000, 16'h0000);
        // reset in mid-run
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({13'h0000, sdOut, intPending, irq}, 16'h0000);
        rd(5'h10);
        chk(d, 16'h0000);
        printVerdict();
    end
endmodule // pss_status_summary_tb_top
